// ===== hw/slot_map_pkg.sv
`default_nettype none
package slot_map_pkg;
  localparam int unsigned NUM_SLOTS   = 64;
  localparam int unsigned SLOT_WORDS  = 18;
  localparam int unsigned NUM_EFFECT  = 18;
  localparam int unsigned NUM_COMMON  = 28;
  localparam int unsigned NUM_MIX     = 16;
  localparam int unsigned MIX_W       = 20;
  // Address regions; the external alias differs only in bits 23:16.
  localparam logic [7:0]  INT_REGION  = 8'h80;
  localparam logic [7:0]  EXT_REGION  = 8'h70;
  localparam logic [23:0] SLOT_BASE   = 24'h800000;
  localparam logic [23:0] SLOT_END    = 24'h801fff;
  localparam logic [23:0] EFFECT_BASE = 24'h802000;
  // Slot word indexes.
  localparam logic [4:0] W_SOURCE  = 5'h00;
  localparam logic [4:0] W_DECAY   = 5'h05;
  localparam logic [4:0] W_PITCH   = 5'h06;
  localparam logic [4:0] W_MOD     = 5'h07;
  localparam logic [4:0] W_MIX     = 5'h08;
  localparam logic [4:0] W_DIRECT  = 5'h09;
  localparam logic [4:0] W_LEVEL   = 5'h0a;
  localparam logic [4:0] W_FLV0    = 5'h0b;
  localparam logic [4:0] W_FRATE_A = 5'h10;
  localparam logic [4:0] W_FRATE_B = 5'h11;
  localparam int unsigned NOISE_BIT = 9;
  localparam int unsigned LINK_BIT  = 14;
  localparam logic [4:0]  Q_PASS    = 5'h04;
  localparam logic [12:0] FLV_PASS  = 13'h1ff8;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  // Common register offsets (normalised to the internal region, except the three in region 0x71).
  localparam logic [23:0] COMMON_OFFS [NUM_COMMON] = '{
    24'h802c00, 24'h710000, 24'h710004, 24'h710008,
    24'h802800, 24'h802804, 24'h802808, 24'h80280c,
    24'h802810, 24'h802814, 24'h802880, 24'h802884,
    24'h802888, 24'h80288c, 24'h802890, 24'h802894,
    24'h802898, 24'h80289c, 24'h8028a0, 24'h8028a4,
    24'h8028a8, 24'h8028ac, 24'h8028b0, 24'h8028b4,
    24'h8028b8, 24'h8028bc, 24'h802d00, 24'h802d04};
  localparam logic [15:0] COMMON_MASK [NUM_COMMON] = '{
    16'hff01, 16'hffff, 16'hffff, 16'h0001,
    16'h833f, 16'h6fff, 16'h1fff, 16'h7fff,
    16'hffff, 16'hffff, 16'hfe0f, 16'hfffc,
    16'hfffc, 16'hfffd, 16'h07ff, 16'h07ff,
    16'h07ff, 16'h07ff, 16'h07ff, 16'h07ff,
    16'h00ff, 16'h00ff, 16'h00ff, 16'h07ff,
    16'h07ff, 16'h07ff, 16'h00ff, 16'h01ff};
  localparam logic [4:0] IDX_SERIAL_IN = 5'd6;
  localparam logic [4:0] IDX_ENV_MON   = 5'd8;
  localparam logic [4:0] IDX_POS_MON   = 5'd9;
endpackage
`default_nettype wire

// ===== hw/sound_slot_parameter_map.sv
// What this block does
// - With link set, passing loop start jumps envelope to decay 1 unless zero.
// - Octave field is signed: 8..F mean -8..-1, 0..7 mean 0..+7.
// - Pitch ratio is (1024 + fraction) / 1024 scaled by the octave.
// - One fraction step is about 1.69 cents.
// - Modulator reset bit holds the oscillator; ignored when noise is input.
// - Five-bit modulator rate per slot; ignored when noise is input.
// - Per slot wave shapes and depths for amplitude and pitch modulation.
// - Four-bit index routes slot into double-buffered DSP mix entries.
// - Total level adds to envelope attenuation in the log domain.
// - Five-bit direct pan per slot and pan per effect channel.
// - Send levels: 0 mutes, 1 is -42 dB, 3 dB per code to 0 dB.
// - Resonance gain is 0.75 dB times code minus 3 dB.
// - Five 13-bit cutoff levels chosen by filter envelope stage.
// - Resonance 4 with all cutoffs 0x1FF8 passes the signal unfiltered.
// - Four 5-bit filter envelope rates for attack, decay 1, 2, release.
// - Host uses 4-byte accesses, lower 16 bits; both aliases decode alike.
`timescale 1ns/10ps
`default_nettype none
module sound_slot_parameter_map #(
  parameter int unsigned PITCH_W = 26
) (
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [23:0]           host_addr,
  input  wire logic [3:0]            host_byte_en,
  input  wire logic                  host_wr,
  input  wire logic                  host_rd,
  input  wire logic [31:0]           host_wdata,
  output logic      [31:0]           host_rdata,
  output logic                       host_rd_valid,
  input  wire logic [5:0]            slot_sel,
  input  wire logic                  loop_start_passed,
  input  wire logic [12:0]           amplitude_envelope,
  input  wire logic [2:0]            filter_stage,
  output logic      [PITCH_W-1:0]    pitch_step,
  output logic                       env_jump_decay1,
  output logic                       mod_osc_hold_reset,
  output logic      [4:0]            mod_osc_rate,
  output logic      [1:0]            amp_mod_wave_shape,
  output logic      [1:0]            pitch_mod_wave_shape,
  output logic      [2:0]            amp_mod_depth,
  output logic      [2:0]            pitch_mod_depth,
  output logic      [13:0]           slot_attenuation,
  output logic      [4:0]            direct_pan,
  output logic                       direct_mute,
  output logic      [5:0]            direct_atten_db,
  output logic      [7:0]            resonance_gain_qdb,
  output logic      [12:0]           filter_cutoff_now,
  output logic      [4:0]            filter_envelope_speed,
  output logic                       filter_bypass,
  input  wire logic [4:0]            effect_sel,
  output logic      [4:0]            effect_pan,
  output logic                       effect_mute,
  output logic      [5:0]            effect_atten_db,
  input  wire logic                  mix_valid,
  input  wire logic [5:0]            mix_slot,
  input  wire logic signed [15:0]    mix_sample,
  input  wire logic                  mix_swap,
  input  wire logic [3:0]            dsp_read_index,
  output logic      [slot_map_pkg::MIX_W-1:0] dsp_mix_input,
  input  wire logic [15:0]           serial_in_status,
  input  wire logic [15:0]           envelope_status,
  input  wire logic [15:0]           play_position
);
  import slot_map_pkg::*;

  typedef struct packed {
    logic [31:0]                        rdata;
    logic                               rd_valid;
    logic [NUM_COMMON-1:0][15:0]        common;
    logic [NUM_EFFECT-1:0][15:0]        effect;
    logic [1:0][NUM_MIX-1:0][MIX_W-1:0] mix;
    logic                               fill_bank;
    logic [MIX_W-1:0]                   dsp_out;
    logic [PITCH_W-1:0]                 step;
    logic                               jump;
    logic                               hold;
    logic [4:0]                         rate;
    logic [1:0]                         a_wave;
    logic [1:0]                         p_wave;
    logic [2:0]                         a_depth;
    logic [2:0]                         p_depth;
    logic [13:0]                        atten;
    logic [4:0]                         d_pan;
    logic                               d_mute;
    logic [5:0]                         d_db;
    logic [7:0]                         q_gain;
    logic [12:0]                        cutoff;
    logic [4:0]                         f_speed;
    logic                               bypass;
    logic [4:0]                         e_pan;
    logic                               e_mute;
    logic [5:0]                         e_db;
  } state_s;

  state_s state_r;
  state_s state_nxt;

  // Each slot owns its own words, so no slot sees another's settings.
  logic [15:0] slot_mem [NUM_SLOTS*SLOT_WORDS];
  // The memory has no reset, so software must load a slot before use.
  // Clearing it would need a sweep of over a thousand cycles after reset.

  // 0 dB at code 15, 3 dB per step, code 0 flagged as mute by the caller.
  function automatic logic [5:0] send_db(input logic [3:0] code);
    send_db = 6'(3 * (15 - int'(code)));
  endfunction

  function automatic logic is_mute(input logic [3:0] code);
    is_mute = (code == 4'h0);
  endfunction

  function automatic logic [10:0] slot_word(input logic [5:0] slot,
                                            input logic [4:0] word);
    slot_word = 11'(int'(slot) * SLOT_WORDS + int'(word));
  endfunction

  // Host address decode; the external alias maps onto the internal one.
  logic [23:0] norm_addr;
  logic        full_word;
  logic        slot_hit;
  logic        effect_hit;
  logic        common_hit;
  logic [4:0]  common_idx;
  logic [4:0]  reg_word;
  logic [10:0] host_slot_addr;

  // A stray address matches no region, so it reads zero and drops writes.
  always_comb begin
    norm_addr = host_addr;
    if (host_addr[23:16] == EXT_REGION) begin
      norm_addr = {INT_REGION, host_addr[15:0]};
    end
    full_word  = (host_byte_en == 4'hf);
    reg_word   = norm_addr[6:2];
    slot_hit   = (norm_addr >= SLOT_BASE) && (norm_addr <= SLOT_END) &&
                 (norm_addr[1:0] == 2'h0) && (int'(reg_word) < SLOT_WORDS);
    effect_hit = (norm_addr[23:7] == EFFECT_BASE[23:7]) &&
                 (norm_addr[1:0] == 2'h0) && (int'(reg_word) < NUM_EFFECT);
    common_hit = 1'b0;
    common_idx = 5'h00;
    for (int i = 0; i < NUM_COMMON; i++) begin
      if (norm_addr == COMMON_OFFS[i]) begin
        common_hit = 1'b1;
        common_idx = 5'(i);
      end
    end
    host_slot_addr = slot_word(norm_addr[12:7], reg_word);
  end

  // Parameter words of the slot being played and of the mixing slot.
  logic [15:0] w_src;
  logic [15:0] w_decay;
  logic [15:0] w_pitch;
  logic [15:0] w_mod;
  logic [15:0] w_direct;
  logic [15:0] w_level;
  logic [15:0] w_frate_a;
  logic [15:0] w_frate_b;
  logic [15:0] w_flv [5];
  logic [15:0] w_mixer;

  always_comb begin
    w_src     = slot_mem[slot_word(slot_sel, W_SOURCE)];
    w_decay   = slot_mem[slot_word(slot_sel, W_DECAY)];
    w_pitch   = slot_mem[slot_word(slot_sel, W_PITCH)];
    w_mod     = slot_mem[slot_word(slot_sel, W_MOD)];
    w_direct  = slot_mem[slot_word(slot_sel, W_DIRECT)];
    w_level   = slot_mem[slot_word(slot_sel, W_LEVEL)];
    w_frate_a = slot_mem[slot_word(slot_sel, W_FRATE_A)];
    w_frate_b = slot_mem[slot_word(slot_sel, W_FRATE_B)];
    for (int i = 0; i < 5; i++) begin
      w_flv[i] = slot_mem[slot_word(slot_sel, W_FLV0 + 5'(i))];
    end
    w_mixer   = slot_mem[slot_word(mix_slot, W_MIX)];
  end

  always_ff @(posedge ref_clk) begin
    if (host_wr && full_word && slot_hit) begin
      slot_mem[host_slot_addr] <= host_wdata[15:0];
    end
  end

  // Pitch: the 11-bit mantissa places unity at bit 18 for octave 0.
  // Negative octaves shift right by at most eight, into the eight zero bits
  // below the mantissa, so no fraction bits are lost even at octave -8.
  logic signed [3:0]   octave;
  logic [PITCH_W-1:0]  mantissa;
  logic [PITCH_W-1:0]  step_calc;

  always_comb begin
    octave   = signed'(w_pitch[14:11]);
    mantissa = PITCH_W'({1'b1, w_pitch[9:0]}) << 8;
    if (octave >= 0) begin
      step_calc = mantissa << octave;
    end else begin
      step_calc = mantissa >> (-octave);
    end
  end

  logic              noise_in;
  logic              flv_all_pass;
  logic [4:0]        q_code;
  logic [3:0]        mix_index;
  logic [3:0]        mix_level;
  logic signed [MIX_W-1:0] mix_scaled;
  logic [15:0]       rd_word;

  always_comb begin
    noise_in     = w_src[NOISE_BIT];
    q_code       = w_level[4:0];
    flv_all_pass = 1'b1;
    for (int i = 0; i < 5; i++) begin
      if (w_flv[i][12:0] != FLV_PASS) begin
        flv_all_pass = 1'b0;
      end
    end
    mix_index = w_mixer[3:0];
    mix_level = w_mixer[7:4];
    // A 3 dB step is taken as half a bit of shift; coarse but cheap.
    mix_scaled = MIX_W'(signed'(mix_sample)) >>> ((15 - mix_level) >> 1);
    if (is_mute(mix_level)) begin
      mix_scaled = '0;
    end
    rd_word = 16'h0000;
    if (slot_hit) begin
      rd_word = slot_mem[host_slot_addr];
    end else if (effect_hit) begin
      rd_word = state_r.effect[reg_word];
    end else if (common_hit) begin
      // Monitor registers read straight from their sources, never from the stored copy.
      unique case (common_idx)
        IDX_SERIAL_IN: rd_word = serial_in_status;
        IDX_ENV_MON:   rd_word = envelope_status;
        IDX_POS_MON:   rd_word = play_position;
        default:       rd_word = state_r.common[common_idx];
      endcase
      rd_word = rd_word & COMMON_MASK[common_idx];
    end
  end

  always_comb begin
    state_nxt = state_r;
    // Partial-width accesses are refused outright, reads and writes alike.
    state_nxt.rd_valid = host_rd && full_word;
    if (host_rd && full_word) begin
      state_nxt.rdata = {16'h0000, rd_word};
    end
    if (host_wr && full_word && effect_hit) begin
      state_nxt.effect[reg_word] = host_wdata[15:0];
    end
    if (host_wr && full_word && common_hit) begin
      state_nxt.common[common_idx] =
        host_wdata[15:0] & COMMON_MASK[common_idx];
    end

    // Entries fill in one bank while the DSP reads the other; the sum
    // wraps because nothing guards against overflow.
    if (mix_swap) begin
      state_nxt.fill_bank = ~state_r.fill_bank;
      state_nxt.mix[~state_r.fill_bank] = '0;
    end
    // A sample that arrives with a swap lands in the freshly cleared bank.
    if (mix_valid) begin
      state_nxt.mix[state_nxt.fill_bank][mix_index] =
        state_nxt.mix[state_nxt.fill_bank][mix_index]
        + MIX_W'(mix_scaled);
    end
    state_nxt.dsp_out = state_r.mix[~state_r.fill_bank][dsp_read_index];

    state_nxt.step = step_calc;
    // The jump is a one-cycle decision; the envelope logic acts on it.
    state_nxt.jump = w_decay[LINK_BIT] && loop_start_passed &&
                     (amplitude_envelope != 13'h0000);
    state_nxt.hold    = w_mod[15] && !noise_in;
    state_nxt.rate    = noise_in ? 5'h00 : w_mod[14:10];
    state_nxt.p_wave  = w_mod[9:8];
    state_nxt.p_depth = w_mod[7:5];
    state_nxt.a_wave  = w_mod[4:3];
    state_nxt.a_depth = w_mod[2:0];
    // Attenuations are logarithmic, so the product is a sum.
    state_nxt.atten = 14'(w_level[15:8]) +
                      14'(amplitude_envelope);
    state_nxt.d_pan  = w_direct[4:0];
    state_nxt.d_mute = is_mute(w_direct[11:8]);
    state_nxt.d_db   = send_db(w_direct[11:8]);
    state_nxt.q_gain = 8'(3 * int'(q_code) - 12);
    // Stage codes above four have no level of their own; level 0 stands in.
    state_nxt.cutoff = w_flv[0][12:0];
    if (int'(filter_stage) < 5) begin
      state_nxt.cutoff = w_flv[filter_stage][12:0];
    end
    unique case (filter_stage[1:0])
      2'h0: state_nxt.f_speed = w_frate_a[12:8];
      2'h1: state_nxt.f_speed = w_frate_a[4:0];
      2'h2: state_nxt.f_speed = w_frate_b[12:8];
      2'h3: state_nxt.f_speed = w_frate_b[4:0];
    endcase
    // Bypass is only reported here; the filter datapath acts on it.
    state_nxt.bypass = (q_code == Q_PASS) && flv_all_pass;
    state_nxt.e_pan  = state_r.effect[effect_sel][4:0];
    state_nxt.e_mute = is_mute(state_r.effect[effect_sel][11:8]);
    state_nxt.e_db   = send_db(state_r.effect[effect_sel][11:8]);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign host_rdata            = state_r.rdata;
  assign host_rd_valid         = state_r.rd_valid;
  assign pitch_step            = state_r.step;
  assign env_jump_decay1       = state_r.jump;
  assign mod_osc_hold_reset    = state_r.hold;
  assign mod_osc_rate          = state_r.rate;
  assign amp_mod_wave_shape    = state_r.a_wave;
  assign pitch_mod_wave_shape  = state_r.p_wave;
  assign amp_mod_depth         = state_r.a_depth;
  assign pitch_mod_depth       = state_r.p_depth;
  assign slot_attenuation      = state_r.atten;
  assign direct_pan            = state_r.d_pan;
  assign direct_mute           = state_r.d_mute;
  assign direct_atten_db       = state_r.d_db;
  assign resonance_gain_qdb    = state_r.q_gain;
  assign filter_cutoff_now     = state_r.cutoff;
  assign filter_envelope_speed = state_r.f_speed;
  assign filter_bypass         = state_r.bypass;
  assign effect_pan            = state_r.e_pan;
  assign effect_mute           = state_r.e_mute;
  assign effect_atten_db       = state_r.e_db;
  assign dsp_mix_input         = state_r.dsp_out;

endmodule // sound_slot_parameter_map
`default_nettype wire

// ===== tb/slot_map_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module slot_map_assertions (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [3:0]  host_byte_en,
  input wire logic        host_rd,
  input wire logic [31:0] host_rdata,
  input wire logic        host_rd_valid,
  input wire logic        loop_start_passed,
  input wire logic [12:0] amplitude_envelope,
  input wire logic        env_jump_decay1,
  input wire logic        direct_mute,
  input wire logic [5:0]  direct_atten_db,
  input wire logic        effect_mute,
  input wire logic [5:0]  effect_atten_db,
  input wire logic [7:0]  resonance_gain_qdb,
  input wire logic [2:0]  filter_stage,
  input wire logic [12:0] filter_cutoff_now,
  input wire logic        filter_bypass
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_read_req; host_rd && host_byte_en == 4'hf; endsequence
  sequence s_answer;
    host_rd_valid && host_rdata[31:16] == 16'h0000;
  endsequence
  sequence s_no_read; !host_rd || host_byte_en != 4'hf; endsequence
  property p_read_answer; s_read_req |=> s_answer; endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read not answered with zero upper half");
  property p_no_spurious; s_no_read |=> !host_rd_valid; endproperty
  a_no_spurious: assert property (p_no_spurious)
    else $error("read valid without a full-width read");
  property p_rd_hold; s_no_read |=> $stable(host_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");
  // Link bit is unseen here, so only the blocking causes are checked.
  property p_no_jump;
    !loop_start_passed || amplitude_envelope == 13'h0000 |=> !env_jump_decay1;
  endproperty
  a_no_jump: assert property (p_no_jump)
    else $error("envelope jump without cause");
  property p_dmute; direct_mute |-> direct_atten_db == 6'd45; endproperty
  a_dmute: assert property (p_dmute)
    else $error("direct mute with wrong attenuation");
  property p_dlive; !direct_mute |-> direct_atten_db <= 6'd42; endproperty
  a_dlive: assert property (p_dlive)
    else $error("direct level out of range");
  property p_emute; effect_mute |-> effect_atten_db == 6'd45; endproperty
  a_emute: assert property (p_emute)
    else $error("effect mute with wrong attenuation");
  property p_bypass;
    filter_bypass && $past(filter_stage) <= 3'd4
      |-> filter_cutoff_now == 13'h1ff8 && resonance_gain_qdb == 8'h00;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("bypass with wrong cutoff or gain");
endmodule // slot_map_assertions
bind sound_slot_parameter_map slot_map_assertions u_chk (
  .ref_clk, .rst, .host_byte_en, .host_rd, .host_rdata, .host_rd_valid,
  .loop_start_passed, .amplitude_envelope, .env_jump_decay1, .direct_mute,
  .direct_atten_db, .effect_mute, .effect_atten_db, .resonance_gain_qdb,
  .filter_stage, .filter_cutoff_now, .filter_bypass);
`default_nettype wire

// ===== tb/sound_slot_parameter_map_bench.sv
`timescale 1ns/10ps
`default_nettype none
module sound_slot_parameter_map_bench;
  import slot_map_pkg::*;
  logic        ref_clk = 1'b0, rst = 1'b1, host_wr = 1'b0, host_rd = 1'b0;
  logic [23:0] host_addr = 24'h000000;
  logic [3:0]  host_byte_en = 4'hf, dsp_read_index = 4'h3;
  logic [31:0] host_wdata = 32'h00000000, host_rdata;
  logic [5:0]  slot_sel = 6'h05, mix_slot = 6'h00;
  logic        loop_start_passed = 1'b0, mix_valid = 1'b0, mix_swap = 1'b0;
  logic [12:0] amplitude_envelope = 13'h0123, filter_cutoff_now;
  logic [2:0]  filter_stage = 3'h0, amp_mod_depth, pitch_mod_depth;
  logic [4:0]  effect_sel = 5'h02, mod_osc_rate, direct_pan, effect_pan;
  logic [4:0]  filter_envelope_speed;
  logic signed [15:0] mix_sample = 16'sh0000;
  logic [15:0] serial_in_status = 16'hffff, envelope_status = 16'hffff;
  logic [15:0] play_position = 16'hffff;
  logic [25:0] pitch_step;
  logic [13:0] slot_attenuation;
  logic [1:0]  amp_mod_wave_shape, pitch_mod_wave_shape;
  logic [5:0]  direct_atten_db, effect_atten_db;
  logic [7:0]  resonance_gain_qdb;
  logic [19:0] dsp_mix_input;
  logic        host_rd_valid, env_jump_decay1, mod_osc_hold_reset;
  logic        direct_mute, effect_mute, filter_bypass;
  logic [4:0]  rates [4] = '{5'h11, 5'h0a, 5'h05, 5'h1f};
  int          err_count = 0;
  int          cmp_count = 0;

  sound_slot_parameter_map dut (.ref_clk, .rst, .host_addr, .host_byte_en,
    .host_wr, .host_rd, .host_wdata, .host_rdata, .host_rd_valid, .slot_sel,
    .loop_start_passed, .amplitude_envelope, .filter_stage, .pitch_step,
    .env_jump_decay1, .mod_osc_hold_reset, .mod_osc_rate, .amp_mod_wave_shape,
    .pitch_mod_wave_shape, .amp_mod_depth, .pitch_mod_depth, .slot_attenuation,
    .direct_pan, .direct_mute, .direct_atten_db, .resonance_gain_qdb,
    .filter_cutoff_now, .filter_envelope_speed, .filter_bypass, .effect_sel,
    .effect_pan, .effect_mute, .effect_atten_db, .mix_valid, .mix_slot,
    .mix_sample, .mix_swap, .dsp_read_index, .dsp_mix_input,
    .serial_in_status, .envelope_status, .play_position);

  always #5 ref_clk = ~ref_clk;

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // Upper half is driven with ones so a design honouring it shows up.
  task automatic wr(input logic [23:0] a, input logic [15:0] d,
                    input logic [3:0] be = 4'hf);
    @(negedge ref_clk);
    host_addr = a;
    host_wdata = {16'hffff, d};
    host_byte_en = be;
    host_wr = 1'b1;
    @(negedge ref_clk);
    host_wr = 1'b0;
    host_byte_en = 4'hf;
  endtask

  task automatic rd(input logic [23:0] a, input logic [15:0] e,
                    input string n);
    int k;
    @(negedge ref_clk);
    host_addr = a;
    host_rd = 1'b1;
    @(negedge ref_clk);
    host_rd = 1'b0;
    for (k = 0; k < 4 && host_rd_valid !== 1'b1; k++) @(negedge ref_clk);
    if (k == 4) begin
      err_count++;
      complete_run();
    end
    chk(n, host_rdata, {16'h0000, e});
  endtask

  // The stored word lands on one edge and the decoded outputs on the next.
  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  function automatic logic [23:0] sa(input int s, input int w);
    return SLOT_BASE + 24'(s * 128 + w * 4);
  endfunction

  initial begin
    int i;
    logic [25:0] p;
    logic [23:0] a;
    repeat (16) @(negedge ref_clk);
    rst = 1'b0;
    for (i = 0; i < NUM_COMMON; i++) begin
      a = COMMON_OFFS[i];
      if (a[23:16] == INT_REGION && i < 26) a[23:16] = EXT_REGION;
      wr(COMMON_OFFS[i], 16'hffff);
      rd(a, COMMON_MASK[i], "common_ones");
      wr(a, 16'h0000, 4'h3);
      rd(a, COMMON_MASK[i], "common_partial");
      wr(a, 16'h0000);
      rd(COMMON_OFFS[i], i inside {6, 8, 9} ? COMMON_MASK[i] : 16'h0,
         "zero");
    end
    wr(24'h802900, 16'hffff);
    rd(24'h802900, 16'h0000, "unmapped");
    $display("common register test done");
    // Source word zero selects 16-bit PCM, so every octave is usable.
    for (i = 0; i < 2 * SLOT_WORDS; i++) begin
      wr(sa(5 + i / SLOT_WORDS, i % SLOT_WORDS), 16'h0000);
    end
    for (i = 0; i < 16; i++) begin
      wr(sa(5, W_PITCH), {1'b0, 4'(i), 1'b0, 10'h155});
      settle();
      p = 26'((1024 + 'h155) << 8);
      p = (i < 8) ? p << i : p >> (16 - i);
      chk("pitch_step", 32'(pitch_step), 32'(p));
    end
    wr(sa(5, W_PITCH), 16'h0001);
    wr(sa(6, W_PITCH), 16'h0800);
    settle();
    chk("fraction_step", 32'(pitch_step), 32'h40100);
    slot_sel = 6'h06;
    settle();
    chk("other_slot", 32'(pitch_step), 32'h80000);
    slot_sel = 6'h05;
    wr(sa(5, W_MOD), 16'hda6d);
    wr(sa(5, W_SOURCE), 16'h0000);
    settle();
    chk("modulator", 32'({mod_osc_hold_reset, mod_osc_rate,
        pitch_mod_wave_shape, pitch_mod_depth, amp_mod_wave_shape,
        amp_mod_depth}), 32'h0000da6d);
    rd(sa(5, W_MOD) - 24'h100000, 16'hda6d, "slot_alias");
    wr(sa(5, W_SOURCE), 16'h0200);
    settle();
    chk("noise", 32'({mod_osc_hold_reset, mod_osc_rate}), 32'h0);
    $display("pitch and modulator test done");
    for (i = 0; i < 16; i++) begin
      wr(sa(5, W_DIRECT), {4'h0, 4'(i), 3'h0, 5'(i + 3)});
      wr(EFFECT_BASE + 24'h8, {4'h0, 4'(i), 3'h0, 5'(i)});
      settle();
      chk("direct", 32'({direct_mute, direct_pan, direct_atten_db}),
          32'({i == 0, 5'(i + 3), 6'(45 - 3 * i)}));
      chk("effect", 32'({effect_mute, effect_pan, effect_atten_db}),
          32'({i == 0, 5'(i), 6'(45 - 3 * i)}));
    end
    for (i = 0; i < 32; i++) begin
      wr(sa(5, W_LEVEL), {8'(i * 8), 3'h0, 5'(i)});
      settle();
      chk("resonance", 32'(resonance_gain_qdb),
          {24'h000000, 8'(3 * i - 12)});
      chk("attenuation", 32'(slot_attenuation), 32'(i * 8 + 'h123));
    end
    $display("level test done");
    for (i = 0; i < 5; i++) wr(sa(5, W_FLV0 + i), 16'(8 + i * 'h100));
    wr(sa(5, W_FRATE_A), 16'h110a);
    wr(sa(5, W_FRATE_B), 16'h051f);
    for (i = 0; i < 5; i++) begin
      filter_stage = 3'(i);
      settle();
      chk("cutoff", 32'(filter_cutoff_now), 32'(8 + i * 'h100));
      chk("filter_speed", 32'(filter_envelope_speed),
          32'(rates[i % 4]));
    end
    for (i = 0; i < 5; i++) wr(sa(5, W_FLV0 + i), 16'h1ff8);
    wr(sa(5, W_LEVEL), 16'h0004);
    settle();
    chk("bypass", 32'(filter_bypass), 32'h1);
    wr(sa(5, W_FLV0 + 4), 16'h1ff0);
    settle();
    chk("no_bypass", 32'(filter_bypass), 32'h0);
    $display("filter test done");
    wr(sa(5, W_DECAY), 16'h4000);
    loop_start_passed = 1'b1;
    settle();
    chk("jump", 32'(env_jump_decay1), 32'h1);
    amplitude_envelope = 13'h0000;
    settle();
    chk("jump_zero_env", 32'(env_jump_decay1), 32'h0);
    amplitude_envelope = 13'h0123;
    wr(sa(5, W_DECAY), 16'h0000);
    settle();
    chk("jump_unlinked", 32'(env_jump_decay1), 32'h0);
    loop_start_passed = 1'b0;
    $display("loop link test done");
    wr(sa(5, W_MIX), 16'h00f3);
    wr(sa(6, W_MIX), 16'h00d3);
    wr(sa(7, W_MIX), 16'h0003);
    mix_swap = 1'b1;
    @(negedge ref_clk);
    mix_swap = 1'b0;
    mix_valid = 1'b1;
    mix_sample = -16'sd100;
    for (i = 5; i < 8; i++) begin
      mix_slot = 6'(i);
      @(negedge ref_clk);
    end
    mix_valid = 1'b0;
    mix_swap = 1'b1;
    @(negedge ref_clk);
    mix_swap = 1'b0;
    settle();
    chk("mix_sum", 32'(dsp_mix_input), {12'h000, 20'(-150)});
    // Two swaps bring the bank that held the sum back for reading.
    mix_swap = 1'b1;
    repeat (2) @(negedge ref_clk);
    mix_swap = 1'b0;
    settle();
    chk("mix_cleared", 32'(dsp_mix_input), 32'h0);
    $display("mix test done");
    complete_run();
  end
endmodule // sound_slot_parameter_map_bench
`default_nettype wire
